// ---- hw/serial_mem_pkg.sv ----
// shared constants and types for the two-wire serial memory port
package serial_mem_pkg;

    // ------------------------------------------------------------
    // memory organisation and addressing
    // ------------------------------------------------------------
    localparam int         MEM_WORDS      = 16;
    localparam int         ADDR_BITS      = 4;
    localparam logic [3:0] DEVICE_CODE    = 4'hA;
    localparam logic [3:0] PTR_RESET      = 4'h0;
    localparam logic [7:0] MEM_RESET      = 8'hFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int WRITE_TIME_US   = 4000;
    localparam int WRITE_CYCLES    = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SCL_HALF_CYCLES = 4;
    localparam int BIT_COUNT_LAST  = 7;

    // ------------------------------------------------------------
    // host command codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_WRITE,
        CMD_SET_ADDR,
        CMD_READ_CUR,
        CMD_READ_RAND
    } host_cmd_type;

endpackage : serial_mem_pkg

// ---- hw/two_wire_if.sv ----
// two-wire bus between master and memory slave, open-drain resolved
`timescale 1ns/100ps
`default_nettype none
interface two_wire_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // lines pulled up, driven low by any enabled driver whose output is low
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport master (
        output scl_o, scl_oe, sda_m_o, sda_m_oe,
        input  scl, sda
    );
    modport slave (
        output sda_s_o, sda_s_oe,
        input  scl, sda
    );
endinterface : two_wire_if
`default_nettype wire

// ---- hw/serial_mem_slave.sv ----
// memory end of the two-wire port: 16 x 8 store with self-timed write
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module serial_mem_slave #(
    parameter int WRITE_CYCLES = serial_mem_pkg::WRITE_CYCLES
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    // bus
    two_wire_if.slave bus,
    // user side status
    output logic      o_busy,
    output logic [3:0] o_pointer
);
    localparam int WCW = $clog2(WRITE_CYCLES + 1);

    typedef enum logic [2:0] {
        S_IDLE, S_CTRL, S_ADDR, S_WDATA, S_RDATA, S_IGNORE
    } phase_type;

    typedef struct packed {
        logic [1:0]     scl_sync;
        logic [1:0]     sda_sync;
        logic           scl_prev;
        logic           sda_prev;
        phase_type      phase;
        logic [3:0]     bit_cnt;
        logic [7:0]     shreg;
        logic           ack_slot;
        logic           reading;
        logic [3:0]     ptr;
        logic           ptr_bump;
        logic [7:0]     wbuf;
        logic           wbuf_full;
        logic [WCW-1:0] wtimer;
        logic           busy;
        logic           sda_oe;
        logic [3:0]     ptr_out;
    } state_type;

    state_type      s_q;
    state_type      s_d;
    logic [7:0]     mem_q [serial_mem_pkg::MEM_WORDS];
    logic           mem_we;
    logic [3:0]     mem_wa;

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] rx_byte;

    always_comb begin
        scl      = s_q.scl_sync[1];
        sda      = s_q.sda_sync[1];
        scl_rise = scl & ~s_q.scl_prev;
        scl_fall = ~scl & s_q.scl_prev;
        start_c  = scl & s_q.scl_prev & s_q.sda_prev & ~sda;
        stop_c   = scl & s_q.scl_prev & ~s_q.sda_prev & sda;
        rx_byte  = {s_q.shreg[6:0], sda};
    end

    always_comb begin
        s_d          = s_q;
        mem_we       = 1'b0;
        mem_wa       = s_q.ptr;
        s_d.scl_sync = {s_q.scl_sync[0], bus.scl};
        s_d.sda_sync = {s_q.sda_sync[0], bus.sda};
        s_d.scl_prev = scl;
        s_d.sda_prev = sda;
        if (s_q.busy) begin
            if (s_q.wtimer == WCW'(1)) begin
                s_d.busy = 1'b0;
            end
            s_d.wtimer = s_q.wtimer - WCW'(1);
        end
        if (start_c) begin
            s_d.phase     = S_CTRL;
            s_d.bit_cnt   = 4'h0;
            s_d.ack_slot  = 1'b0;
            s_d.sda_oe    = 1'b0;
            s_d.wbuf_full = 1'b0;
        end else if (stop_c) begin
            // commit write, abort otherwise
            // the stop's own clock pulse counts as one bit
            if (s_q.phase == S_WDATA && s_q.wbuf_full && s_q.bit_cnt == 4'h1
                    && !s_q.busy) begin
                mem_we       = 1'b1;
                s_d.busy     = 1'b1;
                s_d.wtimer   = WCW'(WRITE_CYCLES);
                s_d.ptr_bump = 1'b1;
            end
            s_d.phase  = S_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (s_q.phase == S_IDLE || s_q.phase == S_IGNORE) begin
            s_d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            if (s_q.ack_slot) begin
                if (s_q.reading && s_q.phase == S_RDATA && sda) begin
                    s_d.phase = S_IGNORE;
                end
            end else if (s_q.phase == S_RDATA) begin
                // transmit register moves on the falling edge only
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end else begin
                s_d.shreg   = rx_byte;
                s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end
        end else if (scl_fall) begin
            if (s_q.ack_slot) begin
                s_d.ack_slot = 1'b0;
                s_d.sda_oe   = 1'b0;
                s_d.bit_cnt  = 4'h0;
                if (s_q.phase == S_RDATA) begin
                    s_d.reading = 1'b1;
                    s_d.ptr     = s_q.ptr + 4'h1;
                    s_d.shreg   = mem_q[s_q.ptr];
                    s_d.sda_oe  = ~mem_q[s_q.ptr][7];
                end
            end else if (s_q.bit_cnt == 4'h8) begin
                s_d.ack_slot = 1'b1;
                unique case (s_q.phase)
                    S_CTRL: begin
                        if (s_q.shreg[7:4] == serial_mem_pkg::DEVICE_CODE && !s_q.busy) begin
                            s_d.sda_oe = 1'b1;
                            s_d.phase   = s_q.shreg[0] ? S_RDATA : S_ADDR;
                            s_d.reading = 1'b0;
                            // read after a write starts one past it
                            if (s_q.shreg[0] && s_q.ptr_bump) begin
                                s_d.ptr      = s_q.ptr + 4'h1;
                                s_d.ptr_bump = 1'b0;
                            end
                        end else begin
                            s_d.phase = S_IGNORE;
                        end
                    end
                    S_ADDR: begin
                        s_d.ptr    = s_q.shreg[3:0];
                        s_d.ptr_bump = 1'b0;
                        s_d.sda_oe = 1'b1;
                        s_d.phase  = S_WDATA;
                    end
                    S_WDATA: begin
                        s_d.wbuf      = s_q.shreg;
                        s_d.wbuf_full = 1'b1;
                        s_d.sda_oe    = 1'b1;
                    end
                    S_RDATA: begin
                        s_d.sda_oe = 1'b0;
                    end
                    default: begin
                        s_d.phase = S_IGNORE;
                    end
                endcase
            end else if (s_q.phase == S_RDATA && s_q.reading) begin
                s_d.shreg  = {s_q.shreg[6:0], 1'b1};
                s_d.sda_oe = ~s_q.shreg[6];
            end else if (s_q.phase == S_WDATA && s_q.bit_cnt != 4'h0) begin
                s_d.wbuf_full = 1'b0;
            end
        end
        s_d.ptr_out = s_d.ptr;
    end

    // lines seen idle high after reset, so no false edge follows it
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
                     phase: S_IDLE, ptr: serial_mem_pkg::PTR_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // storage array
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (mem_we) begin
            mem_q[mem_wa] <= s_q.wbuf;
        end
    end

    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = s_q.sda_oe;
    assign o_busy       = s_q.busy;
    assign o_pointer    = s_q.ptr_out;
endmodule : serial_mem_slave
`default_nettype wire

// ---- hw/serial_mem_master.sv ----
// bus master end: drives clock, start, stop and byte transfers
`timescale 1ns/100ps
`default_nettype none
module serial_mem_master #(
    parameter int HALF = serial_mem_pkg::SCL_HALF_CYCLES
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    // bus
    two_wire_if.master       bus,
    // command
    input  wire logic        i_req,
    input  wire serial_mem_pkg::host_cmd_type i_cmd,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [3:0]  i_count,
    // answer
    output logic             o_ready,
    output logic             o_done,
    output logic             o_nack,
    output logic             o_rvalid,
    output logic [7:0]       o_rdata
);
    localparam int HW = $clog2(HALF + 1);

    typedef enum logic [3:0] {
        M_IDLE, M_START, M_BIT, M_ACK, M_RSTART, M_STOP, M_STOP2, M_DONE
    } mphase_type;

    typedef struct packed {
        logic [1:0] sda_sync;
        mphase_type phase;
        logic [HW-1:0] tick;
        logic       hi;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [2:0] byte_no;
        logic       rx;
        logic [3:0] left;
        logic       fail;
        serial_mem_pkg::host_cmd_type cmd;
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       scl_low;
        logic       sda_low;
        logic       ready;
        logic       done;
        logic       nack;
        logic       rvalid;
        logic [7:0] rdata;
    } mstate_type;

    mstate_type m_q;
    mstate_type m_d;
    logic       sda;
    logic       step;
    logic       rd;

    always_comb begin
        sda  = m_q.sda_sync[1];
        step = (m_q.tick == HW'(HALF - 1));
        rd   = (m_q.cmd == serial_mem_pkg::CMD_READ_CUR) ||
               (m_q.cmd == serial_mem_pkg::CMD_READ_RAND && m_q.byte_no == 3'h2);
    end

    always_comb begin
        m_d          = m_q;
        m_d.sda_sync = {m_q.sda_sync[0], bus.sda};
        m_d.done     = 1'b0;
        m_d.rvalid   = 1'b0;
        m_d.tick     = step ? '0 : m_q.tick + HW'(1);
        unique case (m_q.phase)
            M_IDLE: begin
                m_d.tick = '0;
                if (i_req && m_q.ready && sda) begin
                    m_d.cmd     = i_cmd;
                    m_d.addr    = i_addr;
                    m_d.wdata   = i_wdata;
                    m_d.left    = i_count;
                    m_d.ready   = 1'b0;
                    m_d.fail    = 1'b0;
                    m_d.byte_no = 3'h0;
                    m_d.phase   = M_START;
                end
            end
            M_START, M_RSTART: begin
                if (step) begin
                    // start: data falls while clock high
                    if (!m_q.sda_low && !m_q.scl_low) begin
                        m_d.sda_low = 1'b1;
                    end else if (m_q.scl_low) begin
                        m_d.scl_low = 1'b0;
                        m_d.sda_low = 1'b0;
                    end else begin
                        m_d.scl_low = 1'b1;
                        m_d.phase   = M_BIT;
                        m_d.bit_cnt = 4'h0;
                        m_d.hi      = 1'b0;
                        m_d.rx      = 1'b0;
                        m_d.sh      = {serial_mem_pkg::DEVICE_CODE, 3'h0, (m_q.byte_no == 3'h2 ||
                                       m_q.cmd == serial_mem_pkg::CMD_READ_CUR)};
                    end
                end
            end
            M_BIT, M_ACK: begin
                if (step) begin
                    if (!m_q.hi) begin
                        if (m_q.phase == M_BIT) begin
                            m_d.sda_low = m_q.rx ? 1'b0 : ~m_q.sh[7];
                        end else begin
                            m_d.sda_low = m_q.rx && (m_q.left > 4'h1);
                        end
                        m_d.hi = 1'b1;
                    end else if (m_q.scl_low) begin
                        m_d.scl_low = 1'b0;
                    end else begin
                        m_d.scl_low = 1'b1;
                        m_d.hi      = 1'b0;
                        if (m_q.phase == M_BIT) begin
                            m_d.sh      = {m_q.sh[6:0], sda};
                            m_d.bit_cnt = m_q.bit_cnt + 4'h1;
                            if (m_q.bit_cnt == 4'(serial_mem_pkg::BIT_COUNT_LAST)) begin
                                m_d.phase = M_ACK;
                            end
                        end else if (m_q.rx) begin
                            m_d.rdata   = m_q.sh;
                            m_d.rvalid  = 1'b1;
                            m_d.sda_low = 1'b0;
                            m_d.left    = m_q.left - 4'h1;
                            m_d.phase   = (m_q.left > 4'h1) ? M_BIT : M_STOP;
                            m_d.bit_cnt = 4'h0;
                        end else if (sda) begin
                            // no acknowledge: report so user can poll
                            m_d.fail  = 1'b1;
                            m_d.phase = M_STOP;
                        end else begin
                            m_d.byte_no = m_q.byte_no + 3'h1;
                            m_d.bit_cnt = 4'h0;
                            m_d.phase   = M_BIT;
                            if (rd) begin
                                m_d.rx      = 1'b1;
                                m_d.sda_low = 1'b0;
                            end else if (m_q.byte_no == 3'h0) begin
                                m_d.sh = {4'h0, m_q.addr};
                            end else if (m_q.byte_no == 3'h1 &&
                                         m_q.cmd == serial_mem_pkg::CMD_WRITE) begin
                                m_d.sh = m_q.wdata;
                            end else if (m_q.byte_no == 3'h1 &&
                                         m_q.cmd == serial_mem_pkg::CMD_READ_RAND) begin
                                m_d.phase   = M_RSTART;
                                m_d.sda_low = 1'b0;
                            end else begin
                                m_d.phase = M_STOP;
                            end
                        end
                    end
                end
            end
            M_STOP: begin
                if (step) begin
                    m_d.sda_low = 1'b1;
                    m_d.phase   = M_STOP2;
                end
            end
            M_STOP2: begin
                // stop: data rises while clock high
                if (step) begin
                    if (m_q.scl_low) begin
                        m_d.scl_low = 1'b0;
                    end else begin
                        m_d.sda_low = 1'b0;
                        m_d.phase   = M_DONE;
                    end
                end
            end
            M_DONE: begin
                m_d.done  = 1'b1;
                m_d.nack  = m_q.fail;
                m_d.ready = 1'b1;
                m_d.phase = M_IDLE;
            end
            default: begin
                m_d.phase = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            m_q <= '{sda_sync: 2'h3, phase: M_IDLE, ready: 1'b1,
                     cmd: serial_mem_pkg::CMD_WRITE, default: '0};
        end else begin
            m_q <= m_d;
        end
    end

    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = m_q.scl_low;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = m_q.sda_low;
    assign o_ready      = m_q.ready;
    assign o_done       = m_q.done;
    assign o_nack       = m_q.nack;
    assign o_rvalid     = m_q.rvalid;
    assign o_rdata      = m_q.rdata;
endmodule : serial_mem_master
`default_nettype wire

// ---- sim/serial_mem_checker.sv ----
// concurrent checks on the two-wire bus between master and memory slave
`timescale 1ns/100ps
`default_nettype none
module serial_mem_checker (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // drivers and resolved lines
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    // ------------------------------------------------------------
    // slave side
    // ------------------------------------------------------------
    property p_slave_hold;
        scl && $past(scl) |-> $stable(sda_s_oe);
    endproperty
    a_slave_hold: assert property (p_slave_hold)
        else $error("slave data moved while clock high");
    property p_slave_low;
        sda_s_oe |-> !sda_s_o;
    endproperty
    a_slave_low: assert property (p_slave_low)
        else $error("slave drove the data line high");
    property p_ack_high;
        $rose(scl) && sda_s_oe |-> sda_s_oe [*4];
    endproperty
    a_ack_high: assert property (p_ack_high)
        else $error("slave low level not held over clock high");
    property p_stop_free;
        $rose(sda) && scl |=> !sda_s_oe [*8];
    endproperty
    a_stop_free: assert property (p_stop_free)
        else $error("slave drove data after stop");
    property p_start_free;
        $rose(sda_m_oe) && scl |-> !sda_s_oe [*8];
    endproperty
    a_start_free: assert property (p_start_free)
        else $error("slave drove data at start");

    // ------------------------------------------------------------
    // master side
    // ------------------------------------------------------------
    property p_idle_start;
        $rose(sda_m_oe) && scl |-> $past(sda) && $past(scl);
    endproperty
    a_idle_start: assert property (p_idle_start)
        else $error("start on a busy bus");
    property p_start_clk;
        $rose(sda_m_oe) && scl |-> ##[1:8] !scl;
    endproperty
    a_start_clk: assert property (p_start_clk)
        else $error("no clock low after start");
    property p_stop_idle;
        $fell(sda_m_oe) && scl && $past(scl) |=> scl [*4];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("clock pulled right after stop");

    c_start: cover property ($rose(sda_m_oe) && scl);
    c_ack: cover property ($rose(scl) && sda_s_oe);
    c_stop: cover property ($fell(sda_m_oe) && scl && $past(scl));
endmodule : serial_mem_checker
`default_nettype wire

// ---- sim/test_i2c_slave_eeprom_16x8_port.sv ----
// self-checking bench: master and memory slave joined on one bus
`timescale 1ns/100ps
`default_nettype none
module test_i2c_slave_eeprom_16x8_port;
    localparam int WCYC  = 200;
    localparam int LIMIT = 40000;
    logic       i_sys_clk = 1'b0;
    logic       i_arst_n  = 1'b0;
    logic       req       = 1'b0;
    logic [3:0] addr      = 4'h0;
    logic [7:0] wdata     = 8'h00;
    logic [3:0] count     = 4'h1;
    logic       ready;
    logic       done;
    logic       nack;
    logic       rvalid;
    logic       busy;
    logic [7:0] rdata;
    logic [3:0] pointer;
    logic [7:0] exp_mem [16];
    logic [7:0] rd_q [$];
    int         error_cnt  = 0;
    int         n_compared = 0;
    int         cycles     = 0;
    serial_mem_pkg::host_cmd_type cmd = serial_mem_pkg::CMD_WRITE;

    two_wire_if bus ();
    serial_mem_slave #(.WRITE_CYCLES(WCYC)) i_serial_mem_slave (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .bus(bus.slave),
        .o_busy(busy), .o_pointer(pointer));
    serial_mem_master i_serial_mem_master (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .bus(bus.master),
        .i_req(req), .i_cmd(cmd), .i_addr(addr), .i_wdata(wdata), .i_count(count),
        .o_ready(ready), .o_done(done), .o_nack(nack), .o_rvalid(rvalid),
        .o_rdata(rdata));
    serial_mem_checker i_serial_mem_checker (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .scl_o(bus.scl_o),
        .scl_oe(bus.scl_oe), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe),
        .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));

    always #25 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk) begin
        if (rvalid === 1'b1) begin
            rd_q.push_back(rdata);
        end
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // compares and command driver
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic run_cmd(input serial_mem_pkg::host_cmd_type c, input logic [3:0] a,
                           input logic [7:0] d, input logic [3:0] n);
        int k;
        k = 0;
        rd_q.delete();
        @(posedge i_sys_clk);
        req <= 1'b1;
        cmd <= c;
        addr <= a;
        wdata <= d;
        count <= n;
        do begin
            @(negedge i_sys_clk);
            k++;
        end while (ready === 1'b1 && k < 40);
        @(posedge i_sys_clk);
        req <= 1'b0;
        do begin
            @(negedge i_sys_clk);
            k++;
        end while (done !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            error_cnt++;
            $display("wrong value at %0t: command never finished", $time);
        end
    endtask : run_cmd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic write_poll(input logic [3:0] a, input logic [7:0] d);
        int k;
        exp_mem[a] = d;
        run_cmd(serial_mem_pkg::CMD_WRITE, a, d, 4'h1);
        chk_flag(nack, 1'b0);
        // the slave sees the stop a few cycles after done
        repeat (3) @(negedge i_sys_clk);
        chk_flag(busy, 1'b1);
        chk_byte({4'h0, pointer}, {4'h0, a});
        run_cmd(serial_mem_pkg::CMD_SET_ADDR, a, 8'h00, 4'h1);
        chk_flag(nack, 1'b1);
        k = 0;
        while (nack !== 1'b0 && k < 10) begin
            run_cmd(serial_mem_pkg::CMD_SET_ADDR, a, 8'h00, 4'h1);
            k++;
        end
        chk_flag(nack, 1'b0);
    endtask : write_poll

    task automatic t_reads;
        run_cmd(serial_mem_pkg::CMD_READ_RAND, 4'h5, 8'h00, 4'h1);
        chk_byte(rd_q[0], exp_mem[5]);
        chk_byte({4'h0, pointer}, 8'h06);
        run_cmd(serial_mem_pkg::CMD_READ_CUR, 4'h0, 8'h00, 4'h1);
        chk_byte(rd_q[0], exp_mem[6]);
        run_cmd(serial_mem_pkg::CMD_READ_RAND, 4'hE, 8'h00, 4'h3);
        chk_byte(rd_q[0], exp_mem[14]);
        chk_byte(rd_q[1], exp_mem[15]);
        chk_byte(rd_q[2], exp_mem[0]);
        chk_byte({4'h0, pointer}, 8'h01);
        chk_byte(8'(rd_q.size()), 8'h03);
    endtask : t_reads

    task automatic t_rewrite;
        int k;
        exp_mem[7] = 8'hC3;
        run_cmd(serial_mem_pkg::CMD_WRITE, 4'h7, 8'hC3, 4'h1);
        chk_flag(nack, 1'b0);
        repeat (3) @(negedge i_sys_clk);
        chk_flag(busy, 1'b1);
        // wait out the write cycle without moving the pointer
        k = 0;
        while (busy !== 1'b0 && k < WCYC + 10) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk_flag(busy, 1'b0);
        run_cmd(serial_mem_pkg::CMD_READ_CUR, 4'h0, 8'h00, 4'h1);
        chk_byte(rd_q[0], exp_mem[8]);
        run_cmd(serial_mem_pkg::CMD_SET_ADDR, 4'h8, 8'h00, 4'h1);
        run_cmd(serial_mem_pkg::CMD_READ_CUR, 4'h0, 8'h00, 4'h1);
        chk_byte(rd_q[0], exp_mem[8]);
        run_cmd(serial_mem_pkg::CMD_READ_RAND, 4'h7, 8'h00, 4'h1);
        chk_byte(rd_q[0], 8'hC3);
    endtask : t_rewrite

    task automatic tally_and_finish;
        $display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk_flag(busy, 1'b0);
        chk_byte({4'h0, pointer}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            write_poll(4'(i), 8'h5A ^ 8'(i * 17));
        end
        t_reads();
        t_rewrite();
        tally_and_finish();
    end
endmodule : test_i2c_slave_eeprom_16x8_port
`default_nettype wire
